// [include/adc_scan_map.svh]
// Offsets, field positions, reset values and counts of the converter scan segment.
// Assumes inclusion from the package, the design modules and the bench.
`ifndef ADC_SCAN_MAP_SVH
`define ADC_SCAN_MAP_SVH

// AXI4-Lite byte offsets
`define OFS_FUNC_CTRL   4'h0
`define OFS_STATUS      4'h4
`define OFS_UPDATE_RB   4'h8
`define OFS_SHIFT_RB    4'hC

// Field positions inside the 31-bit control word
`define FLD_DAC_LO      0
`define FLD_DAC_HI      9
`define FLD_MUX_LO      10
`define FLD_MUX_HI      17
`define FLD_NEG_LO      18
`define FLD_NEG_HI      20
`define FLD_HOLD        21
`define FLD_CMP_LATCH_PRECHARGE_N_N     22
`define FLD_GND         23
`define FLD_VCCREF      24
`define FLD_GAIN_PASSGATE_EN      25
`define FLD_SETTLE      26
`define FLD_SWITCHCAP_TEST_EN      27
`define FLD_AMP_POWER_EN       28
`define FLD_CONVERTER_POWER_EN       29
`define FLD_BANDGAP_REF_TO_DAC_EN      30

// Idle word: DAC 0x200, mux bit 0, hold, precharge off, pass gates on
`define CTRL_IDLE       31'h02600600

// Status bit positions
`define ST_EXTEST       0
`define ST_COMP         1
`define ST_TCK          2

// AXI response codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Length of the pin synchroniser
`define SYNC_STAGES     3

`endif

// [include/adc_scan_pkg.sv]
// Types shared by the converter scan segment.
// Assumes adc_scan_map.svh is on the include path.
package adc_scan_pkg;
    `include "adc_scan_map.svh"
    typedef logic [30:0] ctrl_word_t;  // One control word, all front-end controls
    typedef logic [31:0] chain_t;      // Scan segment: controls plus comparator cell
    typedef logic [1:0]  resp_t;       // AXI response code
endpackage

// [logic/pin_sync.sv]
// Three-stage synchroniser for a group of pins from outside the aclk domain.
// Assumes each bit is an independent level; a change counts when stages one and two agree.
`timescale 1ns/1ps
`include "adc_scan_map.svh"
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    import adc_scan_pkg::*;

    generate
        if (W < 1) begin : g_chk
            $error("pin_sync needs W of at least 1");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [`SYNC_STAGES-1:0] st_r;   // Stage 0 is seen by stage 1 only
            logic [`SYNC_STAGES-1:0] st_nxt;
            logic                    out_r;  // Filtered level
            logic                    out_nxt;

            // Next values of the chain and the filtered level
            always_comb begin
                st_nxt  = {st_r[`SYNC_STAGES-2:0], pin_in[i]};
                out_nxt = (st_r[1] == st_r[2]) ? st_r[2] : out_r;
            end

            // Registers only
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    st_r  <= '0;
                    out_r <= 1'b0;
                end else begin
                    st_r  <= st_nxt;
                    out_r <= out_nxt;
                end
            end
            assign pin_out[i] = out_r;
        end
    endgenerate
endmodule

// [logic/adc_boundary_scan_control.sv]
// Boundary-scan control and observe segment of the converter front end, with AXI4-Lite access.
// Assumes an external TAP controller drives capture/shift/update/extest levels and the test
// clock as pins; all are sampled by aclk, so the test clock must be far slower than aclk.
//
// How it works
// - Hold output low samples, high holds; idle 1
// - Precharge control is active low; idle 1
// - Ground-select true grounds negative input; idle 0
// - Supply-reference select uses supply; idle 0
// - Three-bit negative-input select; idle all zero
// - Pass-gate enable switches gain stages; idle 1
// - Switch-cap test routes x10 stage out; idle 0
// - Converter power control enables converter; idle 0
`timescale 1ns/1ps
`include "adc_scan_map.svh"
module adc_boundary_scan_control
    import adc_scan_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Test access pins from the TAP controller
    input  wire logic              tck,
    input  wire logic              tdi,
    output logic                   tdo,
    input  wire logic              scan_capture,
    input  wire logic              scan_shift,
    input  wire logic              scan_update,
    input  wire logic              extest_en,
    // Analog front end
    input  wire logic              comp_in,
    output logic                   sample_hold,
    output logic                   cmp_latch_precharge_n,
    output logic                   neg_input_ground_sel,
    output logic                   supply_ref_sel,
    output logic [2:0]             neg_input_select,
    output logic [7:0]             input_mux_select,
    output logic                   gain_passgate_en,
    output logic                   settle_assist,
    output logic                   switchcap_test_en,
    output logic                   amp_power_en,
    output logic                   converter_power_en,
    output logic                   bandgap_ref_to_dac_en,
    output logic [9:0]             dac_word
);

    generate
        if (ADDR_W < 4) begin : g_chk
            $error("ADDR_W must cover the four register words");
        end
    endgenerate

    // Synchronised pins: {comp, extest, update, shift, capture, tdi, tck}
    logic [6:0] pins_s;
    pin_sync #(.W(7)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({comp_in, extest_en, scan_update, scan_shift, scan_capture, tdi, tck}),
        .pin_out (pins_s)
    );
    logic tck_s, tdi_s, cap_s, sft_s, upd_s, ext_s, comp_s;
    assign {comp_s, ext_s, upd_s, sft_s, cap_s, tdi_s, tck_s} = pins_s;

    // Scan state
    logic       tck_d_r, tck_d_nxt;    // Previous test clock level
    chain_t     sr_r, sr_nxt;          // Shift/capture stages, bit 0 is the comparator cell
    ctrl_word_t upd_r, upd_nxt;        // Update latch
    logic       tdo_r, tdo_nxt;        // Serial out, changes on falling test clock
    logic       tck_rise, tck_fall;

    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    // Capture, shift and update on test clock edges seen by aclk
    always_comb begin
        tck_d_nxt = tck_s;
        sr_nxt    = sr_r;
        upd_nxt   = upd_r;
        tdo_nxt   = tdo_r;
        if (tck_rise && cap_s) begin
            sr_nxt = {upd_r, comp_s};
        end else if (tck_rise && sft_s) begin
            sr_nxt = {tdi_s, sr_r[31:1]};
        end
        if (tck_fall && upd_s) begin
            upd_nxt = sr_r[31:1];
        end
        if (tck_fall) begin
            tdo_nxt = sr_r[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tck_d_r <= 1'b0;
            sr_r    <= {`CTRL_IDLE, 1'b0};
            upd_r   <= `CTRL_IDLE;
            tdo_r   <= 1'b0;
        end else begin
            tck_d_r <= tck_d_nxt;
            sr_r    <= sr_nxt;
            upd_r   <= upd_nxt;
            tdo_r   <= tdo_nxt;
        end
    end
    assign tdo = tdo_r;

    // Bus-side state
    ctrl_word_t        func_r, func_nxt;      // Functional control word used outside extest
    ctrl_word_t        act_r, act_nxt;        // Word actually driven to the front end
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;  // Held write address
    logic [31:0]       wdata_r, wdata_nxt;    // Held write data
    logic [3:0]        wstrb_r, wstrb_nxt;    // Held byte strobes
    logic              aw_got_r, aw_got_nxt;  // Write address taken
    logic              w_got_r, w_got_nxt;    // Write data taken
    logic              bvalid_r, bvalid_nxt;  // Write response pending
    resp_t             bresp_r, bresp_nxt;    // Write response code
    logic              rvalid_r, rvalid_nxt;  // Read data pending
    resp_t             rresp_r, rresp_nxt;    // Read response code
    logic [31:0]       rdata_r, rdata_nxt;    // Read data
    logic [31:0]       func_ext;              // Byte-lane merge of the functional word
    logic [31:0]       status_w;              // Live status word
    logic              aw_far, ar_far;        // Address beyond the four words

    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ~w_got_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign status_w      = {29'h0, tck_s, comp_s, ext_s};
    // Upper address bits must be zero, otherwise a wide bus would alias the words
    assign aw_far        = (awaddr_r >> 4) != '0;
    assign ar_far        = (s_axi_araddr >> 4) != '0;

    // Write, read and output selection
    always_comb begin
        func_ext   = {1'b0, func_r};
        func_nxt   = func_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        // Address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_nxt = s_axi_awaddr;
            aw_got_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
            w_got_nxt = 1'b1;
        end
        if (aw_got_r && w_got_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = `RESP_OKAY;
            if (aw_far) begin
                bresp_nxt = `RESP_SLVERR;
            end else begin
                case (awaddr_r[3:0])
                    `OFS_FUNC_CTRL: begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_r[b]) begin
                                func_ext[b*8 +: 8] = wdata_r[b*8 +: 8];
                            end
                        end
                    end
                    // Read-only words ignore writes but answer OKAY
                    `OFS_STATUS, `OFS_UPDATE_RB, `OFS_SHIFT_RB: begin
                    end
                    default: begin
                        bresp_nxt = `RESP_SLVERR;
                    end
                endcase
            end
        end
        // Bit 31 has no storage behind it
        func_nxt = func_ext[30:0];
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `RESP_OKAY;
            if (ar_far) begin
                rdata_nxt = 32'h0;
                rresp_nxt = `RESP_SLVERR;
            end else begin
                case (s_axi_araddr[3:0])
                    `OFS_FUNC_CTRL: rdata_nxt = {1'b0, func_r};
                    `OFS_STATUS:    rdata_nxt = status_w;
                    `OFS_UPDATE_RB: rdata_nxt = {1'b0, upd_r};
                    `OFS_SHIFT_RB:  rdata_nxt = sr_r;
                    default: begin
                        rdata_nxt = 32'h0;
                        rresp_nxt = `RESP_SLVERR;
                    end
                endcase
            end
        end
        // Extest hands the front end to the update latch
        act_nxt = ext_s ? upd_r : func_r;
    end

    // Bus and front-end registers; reset leaves every control at its idle value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_r   <= `CTRL_IDLE;
            act_r    <= `CTRL_IDLE;
            awaddr_r <= '0;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= `RESP_OKAY;
            rdata_r  <= 32'h0;
        end else begin
            func_r   <= func_nxt;
            act_r    <= act_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // Bus outputs
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    // Front-end controls, all straight from flip-flops so no glitch reaches the analog side
    assign dac_word              = act_r[`FLD_DAC_HI:`FLD_DAC_LO];
    assign input_mux_select      = act_r[`FLD_MUX_HI:`FLD_MUX_LO];
    assign neg_input_select      = act_r[`FLD_NEG_HI:`FLD_NEG_LO];
    assign sample_hold           = act_r[`FLD_HOLD];
    assign cmp_latch_precharge_n = act_r[`FLD_CMP_LATCH_PRECHARGE_N_N];
    assign neg_input_ground_sel  = act_r[`FLD_GND];
    assign supply_ref_sel        = act_r[`FLD_VCCREF];
    assign gain_passgate_en      = act_r[`FLD_GAIN_PASSGATE_EN];
    assign settle_assist         = act_r[`FLD_SETTLE];
    assign switchcap_test_en     = act_r[`FLD_SWITCHCAP_TEST_EN];
    assign amp_power_en          = act_r[`FLD_AMP_POWER_EN];
    assign converter_power_en    = act_r[`FLD_CONVERTER_POWER_EN];
    assign bandgap_ref_to_dac_en = act_r[`FLD_BANDGAP_REF_TO_DAC_EN];

    // Checks on the scan segment and the bus
    AST_IDLE_RST: assert property (@(posedge aclk) !aresetn |=> (act_r == `CTRL_IDLE))
        else $error("front end not idle after reset");
    AST_EXT_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_s |=> (act_r == $past(upd_r)))
        else $error("extest does not drive from update latch");
    AST_FUNC_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
        !ext_s |=> (act_r == $past(func_r)))
        else $error("functional word not driven outside extest");
    AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
        (tck_rise && cap_s) |=> (sr_r[0] == $past(comp_s)))
        else $error("comparator not captured");
    AST_UPDATE: assert property (@(posedge aclk) disable iff (!aresetn)
        (tck_fall && upd_s) |=> (upd_r == $past(sr_r[31:1])))
        else $error("update latch not loaded");
    AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data dropped early");
    COV_CAPTURE: cover property (@(posedge aclk) disable iff (!aresetn) tck_rise && cap_s);
    COV_UPDATE: cover property (@(posedge aclk) disable iff (!aresetn) tck_fall && upd_s && ext_s);
    COV_SLVERR: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && (s_axi_rresp == `RESP_SLVERR));
endmodule

// [bench/tap_model.sv]
// Test controller model driving the converter scan segment pins.
// Assumes LSB-first shifting; the test clock rests low between frames.
`timescale 1ns/1ps
module tap_model
    import adc_scan_pkg::*;
(
    output logic      tck,
    output logic      tdi,
    input  wire logic tdo,
    output logic      scan_capture,
    output logic      scan_shift,
    output logic      scan_update,
    output logic      extest_en
);
    localparam realtime HALF = 62.5; // 62.5 ns high phase, 187.5 ns test clock period
    // Pins at rest
    initial begin
        {tck, tdi, scan_capture, scan_shift, scan_update, extest_en} = '0;
    end
    // One test clock period; the extra rest lets the aclk synchroniser catch up
    task automatic pulse();
        #HALF tck = 1'b1;
        #HALF tck = 1'b0;
        #HALF;
    endtask
    // Instruction level, set once per phase
    task automatic set_ext(input logic b);
        extest_en = b;
    endtask
    // Shift a word in, collect what comes out, then update
    task automatic load(input ctrl_word_t w, output chain_t q);
        chain_t d;
        d          = {w, 1'b0};  // Comparator cell is bit 0, the controls sit above it
        scan_shift = 1'b1;
        for (int i = 0; i < 32; i++) begin
            tdi  = d[i];
            q[i] = tdo; // Sampled before the shifting edge
            pulse();
        end
        scan_shift  = 1'b0;
        tdi         = ~tdi; // Stale data never looks like a held bit
        scan_update = 1'b1;
        pulse();
        scan_update = 1'b0;
    endtask
    // Comparator result into its cell
    task automatic capture();
        scan_capture = 1'b1;
        pulse();
        scan_capture = 1'b0;
    endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the converter scan segment.
// Assumes the package and the scan map header are compiled first.
`timescale 1ns/1ps
`include "adc_scan_map.svh"
module tb_top
    import adc_scan_pkg::*;
;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, aclk, aresetn, comp_in;
    logic        tck, tdi, tdo, scan_capture, scan_shift, scan_update, extest_en;
    logic        sample_hold, cmp_latch_precharge_n, neg_input_ground_sel, supply_ref_sel;
    logic        gain_passgate_en, settle_assist, switchcap_test_en, amp_power_en;
    logic        converter_power_en, bandgap_ref_to_dac_en;
    logic [2:0]  neg_input_select;
    logic [7:0]  input_mux_select;
    logic [9:0]  dac_word;
    int          err_count = 0;
    int          compares = 0;

    adc_boundary_scan_control #(.ADDR_W(5)) adc_boundary_scan_control_inst (.*);
    tap_model tap_model_inst (.*);

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Analog input sits between the two window limits
    always @(posedge aclk) comp_in <= (dac_word >= 10'h130);

    // Pins gathered in control word layout
    function automatic chain_t obs();
        return {1'b0, bandgap_ref_to_dac_en, converter_power_en, amp_power_en,
                switchcap_test_en, settle_assist, gain_passgate_en, supply_ref_sel,
                neg_input_ground_sel, cmp_latch_precharge_n, sample_hold,
                neg_input_select, input_mux_select, dac_word};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One AXI4-Lite access; handshakes judged at the falling edge, where they are settled
    task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic [1:0] r);
        logic a_ok, w_ok, done;
        done = 1'b0;
        @(posedge aclk);
        if (wr) begin
            {s_axi_awaddr, s_axi_wdata} <= {a, wd};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        while (!done) begin
            @(negedge aclk);
            a_ok = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
            w_ok = s_axi_wvalid && s_axi_wready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            d    = s_axi_rdata;
            r    = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (a_ok) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (done) {s_axi_bready, s_axi_rready} <= 2'h0;
        end
    endtask
    // Reset leaves every control idle
    task automatic t_idle();
        chk(obs(), {1'b0, `CTRL_IDLE});
    endtask
    // Updates reach the pins and the readback
    task automatic t_controls();
        ctrl_word_t  ws[3] = '{31'h09E00200, 31'h567403FF, `CTRL_IDLE};
        logic [31:0] d;
        logic [1:0]  r;
        chain_t      q;
        tap_model_inst.set_ext(1'b1);
        repeat (8) @(posedge aclk);
        axi(1'b0, {1'b0, `OFS_STATUS}, 32'h0, d, r);
        chk({31'h0, d[`ST_EXTEST]}, 32'h1);
        foreach (ws[i]) begin
            tap_model_inst.load(ws[i], q);
            chk(obs(), {1'b0, ws[i]});
            axi(1'b0, {1'b0, `OFS_UPDATE_RB}, 32'h0, d, r);
            chk({1'b0, d[30:0]}, {1'b0, ws[i]});
        end
    endtask
    // Window check: sample, hold, limit, precharge, capture the result
    task automatic t_window();
        logic [9:0]  lim[2] = '{10'h123, 10'h143};
        ctrl_word_t  w;
        chain_t      q;
        logic [31:0] d;
        logic [1:0]  r;
        foreach (lim[i]) begin
            w = 31'h22202000 | {21'h0, lim[i]};
            tap_model_inst.load(31'h22402200, q);
            chk(obs(), 32'h22402200);
            tap_model_inst.load(31'h22602200, q);
            tap_model_inst.load(w | 31'h00400000, q);
            tap_model_inst.load(w, q);
            chk(obs(), {1'b0, w});
            axi(1'b0, {1'b0, `OFS_STATUS}, 32'h0, d, r);
            chk({31'h0, d[`ST_COMP]}, {31'h0, (i == 1)});
            tap_model_inst.capture();
            tap_model_inst.load(31'h22602200, q);
            chk({31'h0, q[0]}, {31'h0, (i == 1)});
        end
    endtask
    // Unmapped access, functional word, leaving external test
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        axi(1'b0, 5'h10, 32'h0, d, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        axi(1'b1, {1'b0, `OFS_FUNC_CTRL}, 32'h22600600, d, r);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
        axi(1'b0, {1'b0, `OFS_FUNC_CTRL}, 32'h0, d, r);
        chk(d, 32'h22600600);
        tap_model_inst.set_ext(1'b0);
        repeat (8) @(posedge aclk);
        chk(obs(), 32'h22600600);
    endtask
    // Main sequence
    initial begin
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, comp_in} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_idle();
        t_controls();
        t_window();
        t_bus();
        tally_and_finish();
    end
    // Hang guard, about two and a half times the expected run
    initial begin
        #200us;
        err_count++;
        tally_and_finish();
    end
endmodule
